// [design/ctlp_device.sv]
// Device end: calibration pin and low-power registers and sleep sequencer.
// Assumes the calibration engine shares i_clock; the link pins are async.
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
module ctlp_device
  import ctlp_pkg::*;
#(
  parameter ctlp_delay_type [7:1] P_SLEEP_CYCLES = {
    CTLP_PERIODS_1099511627904, CTLP_PERIODS_137438953600,
    CTLP_PERIODS_17179869312, CTLP_PERIODS_2147483776,
    CTLP_PERIODS_268435584, CTLP_PERIODS_33554560, CTLP_PERIODS_4194432},
  parameter ctlp_delay_type [3:1] P_WAKE_CYCLES = {CTLP_PERIODS_2147483776,
    CTLP_PERIODS_268435584, CTLP_PERIODS_33554560}
)
(
  input wire logic i_clock,
  input wire logic i_rst,
  ctlp_link_if.device link,
  input wire logic i_foreground_done,
  input wire logic i_cal_stopped,
  input wire logic i_alarm,
  input wire logic i_cal_phase_done,
  output logic o_background_enable,
  output logic o_calibration_trigger,
  output logic o_core_sleep,
  output logic o_cal_start,
  output logic [7:0] o_gain_adjust,
  output logic o_irq
);

  logic [7:0] enable_config_reg, pin_config_reg, soft_trig_reg;
  logic [7:0] lp_control_reg, gain_adjust_reg, rdata_reg, rdata_next;
  logic [CTLP_IRQ_W-1:0] irq_status_reg, irq_mask_reg, events;
  logic pin_meta_reg, pin_sync_reg, status_pin_reg, status_pin_next;
  logic cal_start_reg, trigger, lp_active, trigger_wake;
  logic [2:0] flags_prev_reg, sleep_code;
  logic [1:0] wake_code;
  ctlp_status_sel_type status_sel;
  ctlp_delay_type sleep_cycles, wake_cycles, load_value;
  ctlp_lp_state_type state_reg, state_next;
  logic timer_load, timer_done, settle_done;

  // Register writes; reserved bits are stored as written, except in the interrupt mask
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      enable_config_reg <= CTLP_RST_ENABLE_CONFIG;
      pin_config_reg <= CTLP_RST_PIN_CONFIG;
      soft_trig_reg <= CTLP_RST_SOFT_TRIG;
      lp_control_reg <= CTLP_RST_LP_CONTROL;
      gain_adjust_reg <= CTLP_RST_GAIN_ADJUST;
      irq_mask_reg <= CTLP_RST_IRQ[CTLP_IRQ_W-1:0];
    end
    else if (link.reg_write)
    begin
      unique case (link.reg_addr)
        CTLP_ADDR_ENABLE_CONFIG: enable_config_reg <= link.reg_wdata;
        CTLP_ADDR_PIN_CONFIG: pin_config_reg <= link.reg_wdata;
        CTLP_ADDR_SOFT_TRIG: soft_trig_reg <= link.reg_wdata;
        CTLP_ADDR_LP_CONTROL: lp_control_reg <= link.reg_wdata;
        CTLP_ADDR_GAIN_ADJUST: gain_adjust_reg <= link.reg_wdata;
        CTLP_ADDR_IRQ_MASK: irq_mask_reg <= link.reg_wdata[CTLP_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    rdata_next = 8'h00;
    unique case (link.reg_addr)
      CTLP_ADDR_ENABLE_CONFIG: rdata_next = enable_config_reg;
      CTLP_ADDR_CAL_STATUS:
      begin
        rdata_next[CTLP_FOREGROUND_DONE_FLAG_BIT] = i_foreground_done;
        rdata_next[CTLP_STOPPED_BIT] = i_cal_stopped;
      end
      CTLP_ADDR_PIN_CONFIG: rdata_next = pin_config_reg;
      CTLP_ADDR_SOFT_TRIG: rdata_next = soft_trig_reg;
      CTLP_ADDR_LP_CONTROL: rdata_next = lp_control_reg;
      CTLP_ADDR_IRQ_STATUS: rdata_next[CTLP_IRQ_W-1:0] = irq_status_reg;
      CTLP_ADDR_IRQ_MASK: rdata_next[CTLP_IRQ_W-1:0] = irq_mask_reg;
      CTLP_ADDR_GAIN_ADJUST: rdata_next = gain_adjust_reg;
      default: ;
    endcase
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= link.reg_read ? rdata_next : 8'h00;
  end

  // Two-flop synchroniser on the trigger pin
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= link.trigger_input_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Trigger source selection
  assign trigger = pin_config_reg[CTLP_TRIG_SRC_BIT]
    ? pin_sync_reg
    : soft_trig_reg[CTLP_SOFT_TRIG_BIT];

  // Field decode
  assign status_sel = ctlp_status_sel_type'(
    pin_config_reg[CTLP_STATUS_SEL_LSB +: 2]);
  assign sleep_code = lp_control_reg[CTLP_SLEEP_LSB +: 3];
  assign wake_code = lp_control_reg[CTLP_WAKE_LSB +: 2];
  assign trigger_wake = lp_control_reg[CTLP_TRIG_WAKE_BIT];
  assign lp_active = enable_config_reg[CTLP_BG_EN_BIT]
    & lp_control_reg[CTLP_LOW_POWER_ENABLE_BIT];

  // Status pin source
  always_comb
  begin
    unique case (status_sel)
      CTLP_SEL_FOREGROUND_DONE_FLAG: status_pin_next = i_foreground_done;
      CTLP_SEL_STOPPED: status_pin_next = i_cal_stopped;
      CTLP_SEL_ALARM: status_pin_next = i_alarm;
      CTLP_SEL_LOW: status_pin_next = 1'b0;
    endcase
  end

  // Status pin driven from a flop
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      status_pin_reg <= 1'b0;
    else
      status_pin_reg <= status_pin_next;
  end

  // Sleep and settle lengths; code zero is the fixed short delay
  assign sleep_cycles = (sleep_code == 3'd0) ? CTLP_CYCLES_1152
    : P_SLEEP_CYCLES[sleep_code];
  assign wake_cycles = (wake_code == 2'd0) ? CTLP_CYCLES_1152
    : P_WAKE_CYCLES[wake_code];

  // Sequencer next state and timer loading
  always_comb
  begin
    state_next = state_reg;
    timer_load = 1'b0;
    load_value = sleep_cycles;
    settle_done = 1'b0;
    if (!lp_active)
      state_next = CTLP_ST_IDLE;
    else
    begin
      unique case (state_reg)
        CTLP_ST_IDLE, CTLP_ST_CALIB:
        begin
          if (state_reg == CTLP_ST_IDLE || i_cal_phase_done)
          begin
            state_next = CTLP_ST_SLEEP;
            timer_load = 1'b1;
          end
        end
        CTLP_ST_SLEEP:
        begin
          // Trigger-wake wakes on low; autonomous waits for the timer
          if (trigger_wake ? !trigger : timer_done)
          begin
            state_next = CTLP_ST_SETTLE;
            timer_load = 1'b1;
            load_value = wake_cycles;
          end
        end
        CTLP_ST_SETTLE:
        begin
          if (timer_done)
          begin
            state_next = CTLP_ST_CALIB;
            settle_done = 1'b1;
          end
        end
      endcase
    end
  end

  // Sequencer state and calibration start pulse
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg <= CTLP_ST_IDLE;
      cal_start_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cal_start_reg <= settle_done;
    end
  end

  ctlp_delay_timer ctlp_delay_timer_i
  (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_load(timer_load),
    .i_value(load_value),
    .o_done(timer_done)
  );

  // Rising flags and calibration starts are the interrupt events
  assign events[CTLP_EV_FOREGROUND_DONE_FLAG] = i_foreground_done & ~flags_prev_reg[0];
  assign events[CTLP_EV_STOPPED] = i_cal_stopped & ~flags_prev_reg[1];
  assign events[CTLP_EV_ALARM] = i_alarm & ~flags_prev_reg[2];
  assign events[CTLP_EV_CAL_START] = settle_done;

  // Sticky status, write one to clear, a new event wins
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      flags_prev_reg <= 3'b000;
      irq_status_reg <= CTLP_RST_IRQ[CTLP_IRQ_W-1:0];
    end
    else
    begin
      flags_prev_reg <= {i_alarm, i_cal_stopped, i_foreground_done};
      if (link.reg_write && link.reg_addr == CTLP_ADDR_IRQ_STATUS)
        irq_status_reg <= (irq_status_reg
          & ~link.reg_wdata[CTLP_IRQ_W-1:0]) | events;
      else
        irq_status_reg <= irq_status_reg | events;
    end
  end

  assign link.reg_rdata = rdata_reg;
  assign link.status_output_pin = status_pin_reg;
  assign o_background_enable = enable_config_reg[CTLP_BG_EN_BIT];
  assign o_calibration_trigger = trigger;
  assign o_core_sleep = (state_reg == CTLP_ST_SLEEP);
  assign o_cal_start = cal_start_reg;
  assign o_gain_adjust = gain_adjust_reg;
  assign o_irq = |(irq_status_reg & irq_mask_reg);

endmodule

// [design/ctlp_pkg.sv]
// Shared constants for the calibration trigger and low-power sequencer.
// Assumes one 25 MHz clock; every delay is counted in clock periods.
package ctlp_pkg;

  // Register offsets inside the device
  localparam logic [7:0] CTLP_ADDR_ENABLE_CONFIG = 8'h60;
  localparam logic [7:0] CTLP_ADDR_CAL_STATUS = 8'h6a;
  localparam logic [7:0] CTLP_ADDR_PIN_CONFIG = 8'h6b;
  localparam logic [7:0] CTLP_ADDR_SOFT_TRIG = 8'h6c;
  localparam logic [7:0] CTLP_ADDR_LP_CONTROL = 8'h6e;
  localparam logic [7:0] CTLP_ADDR_IRQ_STATUS = 8'h70;
  localparam logic [7:0] CTLP_ADDR_IRQ_MASK = 8'h71;
  localparam logic [7:0] CTLP_ADDR_GAIN_ADJUST = 8'h7a;

  // Reset values
  localparam logic [7:0] CTLP_RST_ENABLE_CONFIG = 8'h00;
  localparam logic [7:0] CTLP_RST_PIN_CONFIG = 8'h00;
  localparam logic [7:0] CTLP_RST_SOFT_TRIG = 8'h01;
  localparam logic [7:0] CTLP_RST_LP_CONTROL = 8'h88;
  localparam logic [7:0] CTLP_RST_GAIN_ADJUST = 8'h00;
  localparam logic [7:0] CTLP_RST_IRQ = 8'h00;

  // Field positions
  localparam int CTLP_BG_EN_BIT = 1;
  localparam int CTLP_TRIG_SRC_BIT = 0;
  localparam int CTLP_STATUS_SEL_LSB = 1;
  localparam int CTLP_SOFT_TRIG_BIT = 0;
  localparam int CTLP_LOW_POWER_ENABLE_BIT = 0;
  localparam int CTLP_TRIG_WAKE_BIT = 1;
  localparam int CTLP_WAKE_LSB = 3;
  localparam int CTLP_SLEEP_LSB = 5;
  localparam int CTLP_FOREGROUND_DONE_FLAG_BIT = 0;
  localparam int CTLP_STOPPED_BIT = 1;

  // Interrupt event bits
  localparam int CTLP_IRQ_W = 4;
  localparam int CTLP_EV_FOREGROUND_DONE_FLAG = 0;
  localparam int CTLP_EV_STOPPED = 1;
  localparam int CTLP_EV_ALARM = 2;
  localparam int CTLP_EV_CAL_START = 3;

  // Status pin source codes
  typedef enum logic [1:0]
  {
    CTLP_SEL_FOREGROUND_DONE_FLAG = 2'b00,
    CTLP_SEL_STOPPED = 2'b01,
    CTLP_SEL_ALARM = 2'b10,
    CTLP_SEL_LOW = 2'b11
  } ctlp_status_sel_type;

  // Low-power sequencer states
  typedef enum logic [1:0]
  {
    CTLP_ST_IDLE = 2'b00,
    CTLP_ST_SLEEP = 2'b01,
    CTLP_ST_SETTLE = 2'b10,
    CTLP_ST_CALIB = 2'b11
  } ctlp_lp_state_type;

  // Delays in clock periods; one clock cycle per period
  localparam int CTLP_DELAY_W = 41;
  typedef logic [CTLP_DELAY_W-1:0] ctlp_delay_type;
  localparam ctlp_delay_type CTLP_CYCLES_PER_PERIOD = 41'h000_0000_0001;
  localparam ctlp_delay_type CTLP_PERIODS_1152 = 41'h000_0000_0480;
  localparam ctlp_delay_type CTLP_PERIODS_4194432 = 41'h000_0040_0080;
  localparam ctlp_delay_type CTLP_PERIODS_33554560 = 41'h000_0200_0080;
  localparam ctlp_delay_type CTLP_PERIODS_268435584 = 41'h000_1000_0080;
  localparam ctlp_delay_type CTLP_PERIODS_2147483776 = 41'h000_8000_0080;
  localparam ctlp_delay_type CTLP_PERIODS_17179869312 = 41'h004_0000_0080;
  localparam ctlp_delay_type CTLP_PERIODS_137438953600 = 41'h020_0000_0080;
  localparam ctlp_delay_type CTLP_PERIODS_1099511627904 = 41'h100_0000_0080;
  localparam ctlp_delay_type CTLP_CYCLES_1152 =
    CTLP_PERIODS_1152 * CTLP_CYCLES_PER_PERIOD;

  // Host controller own registers
  localparam int CTLP_HOST_DEV_BIT = 8;
  localparam logic [8:0] CTLP_HOST_ADDR_CTRL = 9'h000;
  localparam logic [8:0] CTLP_HOST_ADDR_STATUS = 9'h001;
  localparam logic [7:0] CTLP_RST_HOST_CTRL = 8'h01;
  localparam int CTLP_HOST_TRIG_BIT = 0;
  localparam int CTLP_HOST_STAT_BIT = 0;

endpackage

// [design/ctlp_link_if.sv]
// Link between the calibration device end and the host end.
// Assumes both ends share one clock; the testbench instantiates it.
`timescale 1ns/10ps
interface ctlp_link_if;
  logic trigger_input_pin;
  logic status_output_pin;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [7:0] reg_rdata;

  modport device
  (
    input trigger_input_pin,
    output status_output_pin,
    input reg_addr,
    input reg_wdata,
    input reg_write,
    input reg_read,
    output reg_rdata
  );

  modport host
  (
    output trigger_input_pin,
    input status_output_pin,
    output reg_addr,
    output reg_wdata,
    output reg_write,
    output reg_read,
    input reg_rdata
  );
endinterface

// [design/ctlp_delay_timer.sv]
// Down counter for the sleep and settle delays.
// Assumes the loader pulses i_load for one cycle with a nonzero value.
`timescale 1ns/10ps
module ctlp_delay_timer
  import ctlp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_load,
  input wire ctlp_delay_type i_value,
  output logic o_done
);

  ctlp_delay_type count_reg;

  // Load, then count down to zero and hold there
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      count_reg <= '0;
    else if (i_load)
      count_reg <= i_value;
    else if (count_reg != '0)
      count_reg <= count_reg - CTLP_CYCLES_PER_PERIOD;
  end

  // Done once the loaded number of edges has passed
  assign o_done = (count_reg == '0);

endmodule

// [design/ctlp_host.sv]
// Host end: drives the trigger pin, watches the status pin, and bridges
// software to the device registers. Assumes the device shares i_clock.
`timescale 1ns/10ps
module ctlp_host
  import ctlp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  ctlp_link_if.host link,
  input wire logic [8:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  output logic o_status_level
);

  logic [7:0] ctrl_reg;
  logic [7:0] own_rdata_reg;
  logic dev_read_reg;
  logic stat_meta_reg;
  logic stat_sync_reg;
  logic dev_sel;

  assign dev_sel = i_addr[CTLP_HOST_DEV_BIT];

  // Trigger level register; reset high so an unused trigger idles high
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      ctrl_reg <= CTLP_RST_HOST_CTRL;
    else if (i_write && i_addr == CTLP_HOST_ADDR_CTRL)
      ctrl_reg <= i_wdata;
  end

  // Two-flop synchroniser on the status pin
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      stat_meta_reg <= 1'b0;
      stat_sync_reg <= 1'b0;
    end
    else
    begin
      stat_meta_reg <= link.status_output_pin;
      stat_sync_reg <= stat_meta_reg;
    end
  end

  // Own read data and device read tracking, one cycle after the strobe
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      own_rdata_reg <= 8'h00;
      dev_read_reg <= 1'b0;
    end
    else
    begin
      dev_read_reg <= i_read & dev_sel;
      own_rdata_reg <= 8'h00;
      if (i_read && i_addr == CTLP_HOST_ADDR_CTRL)
        own_rdata_reg <= ctrl_reg;
      else if (i_read && i_addr == CTLP_HOST_ADDR_STATUS)
        own_rdata_reg[CTLP_HOST_STAT_BIT] <= stat_sync_reg;
    end
  end

  // Device accesses pass straight through; software keeps reserved
  // bits at their reset values
  assign link.reg_addr = i_addr[7:0];
  assign link.reg_wdata = i_wdata;
  assign link.reg_write = i_write & dev_sel;
  assign link.reg_read = i_read & dev_sel;
  assign link.trigger_input_pin = ctrl_reg[CTLP_HOST_TRIG_BIT];
  assign o_rdata = dev_read_reg ? link.reg_rdata : own_rdata_reg;
  assign o_status_level = stat_sync_reg;

endmodule

// [sim/ctlp_properties.sv]
// Checker for the register lines and status pin of the calibration link.
// Assumes one clock domain; the bench instantiates it beside the link.
`timescale 1ns/10ps
module ctlp_properties
  import ctlp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic trigger_input_pin,
  input wire logic status_output_pin,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata
);
  logic [7:0] cfg_reg;
  logic [7:0] pin_reg;
  logic [7:0] soft_reg;
  logic [7:0] lp_reg;
  logic [7:0] mask_reg;
  logic known_addr;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  // Offsets that answer a read with stored or live data
  assign known_addr = reg_addr inside {CTLP_ADDR_ENABLE_CONFIG,
    CTLP_ADDR_CAL_STATUS, CTLP_ADDR_PIN_CONFIG, CTLP_ADDR_SOFT_TRIG,
    CTLP_ADDR_LP_CONTROL, CTLP_ADDR_IRQ_STATUS, CTLP_ADDR_IRQ_MASK,
    CTLP_ADDR_GAIN_ADJUST};

  // Shadow copies of the stored registers other than gain adjust, fed from the write strobe
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      cfg_reg <= CTLP_RST_ENABLE_CONFIG;
      pin_reg <= CTLP_RST_PIN_CONFIG;
      soft_reg <= CTLP_RST_SOFT_TRIG;
      lp_reg <= CTLP_RST_LP_CONTROL;
      mask_reg <= CTLP_RST_IRQ;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        CTLP_ADDR_ENABLE_CONFIG: cfg_reg <= reg_wdata;
        CTLP_ADDR_PIN_CONFIG: pin_reg <= reg_wdata;
        CTLP_ADDR_SOFT_TRIG: soft_reg <= reg_wdata;
        CTLP_ADDR_LP_CONTROL: lp_reg <= reg_wdata;
        CTLP_ADDR_IRQ_MASK: mask_reg <= 8'(reg_wdata[CTLP_IRQ_W-1:0]);
        default: ;
      endcase
    end
  end

  pin_cfg_read_a: assert property (
    reg_read && reg_addr == CTLP_ADDR_PIN_CONFIG
    |=> reg_rdata == $past(pin_reg))
    else $error("Pin config read back wrong");
  soft_trig_read_a: assert property (
    reg_read && reg_addr == CTLP_ADDR_SOFT_TRIG
    |=> reg_rdata == $past(soft_reg))
    else $error("Soft trigger read back wrong");
  lp_ctrl_read_a: assert property (
    reg_read && reg_addr == CTLP_ADDR_LP_CONTROL
    |-> ##1 reg_rdata == $past(lp_reg))
    else $error("Low-power control read back wrong");
  enable_read_a: assert property (
    $past(reg_read && reg_addr == CTLP_ADDR_ENABLE_CONFIG)
    |-> reg_rdata == $past(cfg_reg))
    else $error("Enable config read back wrong");
  mask_read_a: assert property (
    reg_read && reg_addr == CTLP_ADDR_IRQ_MASK
    |=> reg_rdata == $past(mask_reg))
    else $error("Interrupt mask read back wrong");
  status_low_a: assert property (
    (pin_reg[2:1] == 2'b11) [*2] |-> !status_output_pin)
    else $error("Status pin not low for select three");
  status_ro_a: assert property (
    reg_read && reg_addr == CTLP_ADDR_CAL_STATUS
    |=> reg_rdata[7:2] == 6'h00)
    else $error("Status upper bits not zero");
  rdata_idle_a: assert property (
    !$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("Read data outside its cycle");
  unmapped_read_a: assert property (
    reg_read && !known_addr |=> reg_rdata == 8'h00)
    else $error("Unmapped offset read not zero");

  // Main scenarios reached
  cover property (reg_write && reg_addr == CTLP_ADDR_LP_CONTROL);
  cover property (pin_reg[2:1] == 2'b11 && !status_output_pin);
  cover property ($fell(trigger_input_pin));
endmodule

// [sim/cal_trigger_lowpower_ctrl_tb_top.sv]
// Bench driving the host port and engine flags of both joined ends.
// Assumes a 25 MHz clock and shortened low-power delay parameters.
`timescale 1ns/10ps
module cal_trigger_lowpower_ctrl_tb_top
  import ctlp_pkg::*;
;
  localparam int SLP_BASE = 16;
  localparam int WAK_BASE = 24;
  logic i_clock;
  logic i_rst;
  logic [8:0] i_addr;
  logic [7:0] i_wdata;
  logic i_write;
  logic i_read;
  logic [7:0] o_rdata;
  logic o_status_level;
  logic i_foreground_done;
  logic i_cal_stopped;
  logic i_alarm;
  logic i_cal_phase_done;
  logic o_background_enable;
  logic o_calibration_trigger;
  logic o_core_sleep;
  logic o_cal_start;
  logic [7:0] o_gain_adjust;
  logic o_irq;
  logic [7:0] rd_val;
  int n_fail;
  int n_tests;

  ctlp_link_if ctlp_link_if_i ();
  // Nonzero sleep code k lasts SLP_BASE+k cycles, nonzero wake code k WAK_BASE+k
  ctlp_device #(
    .P_SLEEP_CYCLES({41'h17, 41'h16, 41'h15, 41'h14, 41'h13, 41'h12,
      41'h11}),
    .P_WAKE_CYCLES({41'h1b, 41'h1a, 41'h19})
  ) ctlp_device_i (
    .i_clock, .i_rst, .link(ctlp_link_if_i), .i_foreground_done,
    .i_cal_stopped, .i_alarm, .i_cal_phase_done, .o_background_enable,
    .o_calibration_trigger, .o_core_sleep, .o_cal_start, .o_gain_adjust,
    .o_irq
  );
  ctlp_host ctlp_host_i (
    .i_clock, .i_rst, .link(ctlp_link_if_i), .i_addr, .i_wdata, .i_write,
    .i_read, .o_rdata, .o_status_level
  );
  ctlp_properties ctlp_properties_i (
    .i_clock, .i_rst,
    .trigger_input_pin(ctlp_link_if_i.trigger_input_pin),
    .status_output_pin(ctlp_link_if_i.status_output_pin),
    .reg_addr(ctlp_link_if_i.reg_addr),
    .reg_wdata(ctlp_link_if_i.reg_wdata),
    .reg_write(ctlp_link_if_i.reg_write),
    .reg_read(ctlp_link_if_i.reg_read),
    .reg_rdata(ctlp_link_if_i.reg_rdata)
  );

  // Free running clock
  initial
  begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog against a hung wait
  initial
  begin
    #1_000_000;
    n_fail++;
    tally_and_finish();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(inout int k);
    @(posedge i_clock);
    #1;
    k++;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_write <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a);
    @(posedge i_clock);
    i_read <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1;
    rd_val = o_rdata;
  endtask

  // Reset values, an unmapped offset and the host control register
  task automatic t_reset();
    logic [8:0] ad [8] = '{9'h16b, 9'h16c, 9'h16e, 9'h160, 9'h17a,
      9'h171, 9'h165, 9'h000};
    logic [7:0] ev [8] = '{8'h00, 8'h01, 8'h88, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h01};
    for (int i = 0; i < 8; i++)
    begin
      rd(ad[i]);
      chk(rd_val, ev[i]);
    end
    chk(o_calibration_trigger, 1);
  endtask

  // Every status select code against two flag patterns
  task automatic t_status();
    logic [3:0] f;
    for (int p = 0; p < 2; p++)
    begin
      f = p ? 4'h2 : 4'h5;
      @(posedge i_clock);
      i_foreground_done <= f[0];
      i_cal_stopped <= f[1];
      i_alarm <= f[2];
      for (int s = 0; s < 4; s++)
      begin
        wr(9'h16b, 8'(s << 1));
        wait_n(4);
        chk(o_status_level, f[s]);
      end
      rd(9'h16a);
      chk(rd_val, {6'h00, f[1:0]});
    end
  endtask

  // Sticky event bit, mask and write-one clear
  task automatic t_irq();
    wr(9'h170, 8'h0f);
    rd(9'h170);
    chk(rd_val, 8'h00);
    @(posedge i_clock);
    i_foreground_done <= 1'b1;
    wait_n(3);
    rd(9'h170);
    chk(rd_val, 8'h01);
    chk(o_irq, 0);
    wr(9'h171, 8'h02);
    wait_n(1);
    chk(o_irq, 0);
    wr(9'h171, 8'h01);
    wait_n(1);
    chk(o_irq, 1);
    wr(9'h170, 8'h01);
    wait_n(1);
    chk(o_irq, 0);
    wr(9'h171, 8'h00);
    wr(9'h17a, 8'h5a);
    wait_n(1);
    chk(o_gain_adjust, 8'h5a);
  endtask

  // Trigger source selection with pin and soft bit set apart
  task automatic t_trigger();
    wr(9'h16c, 8'h00);
    wait_n(1);
    chk(o_calibration_trigger, 0);
    wr(9'h16b, 8'h01);
    wait_n(1);
    chk(o_calibration_trigger, 1);
    wr(9'h000, 8'h00);
    wait_n(1);
    chk(o_calibration_trigger, 1);
    wait_n(3);
    chk(o_calibration_trigger, 0);
    wr(9'h16c, 8'h01);
    wait_n(1);
    chk(o_calibration_trigger, 0);
    wr(9'h16b, 8'h00);
    wait_n(1);
    chk(o_calibration_trigger, 1);
  endtask

  // One autonomous sleep, settle and calibration start
  task automatic lp_run(input logic [2:0] sc, input logic [1:0] wc);
    int n;
    int en;
    int em;
    en = (sc == 0) ? int'(CTLP_CYCLES_1152) : SLP_BASE + sc;
    em = (wc == 0) ? int'(CTLP_CYCLES_1152) : WAK_BASE + wc;
    wr(9'h16e, {sc, wc, 3'b001});
    n = 0;
    while (o_core_sleep !== 1'b1 && n < 8)
      step(n);
    n = 0;
    while (o_core_sleep === 1'b1 && n < 3000)
      step(n);
    chk(n, en + 1);
    n = 0;
    while (o_cal_start !== 1'b1 && n < 3000)
      step(n);
    chk(n, em + 1);
    wait_n(1);
    chk(o_cal_start, 0);
    @(posedge i_clock);
    i_cal_phase_done <= 1'b1;
    @(posedge i_clock);
    i_cal_phase_done <= 1'b0;
    #1;
    chk(o_core_sleep, 1);
    wr(9'h16e, {sc, wc, 3'b000});
  endtask

  // Gating by background enable, then every sleep and wake code
  task automatic t_lp();
    wr(9'h16e, 8'h29);
    wait_n(30);
    chk(o_core_sleep, 0);
    wr(9'h16e, 8'h28);
    wr(9'h160, 8'h02);
    wait_n(1);
    chk(o_background_enable, 1);
    for (int s = 0; s < 8; s++)
      lp_run(3'(s), 2'b01);
    for (int w = 0; w < 4; w++)
      lp_run(3'b001, 2'(w));
  endtask

  // Trigger-wake mode: sleep while the pin is high, wake when low
  task automatic t_trig_wake();
    int n;
    wr(9'h16b, 8'h01);
    wr(9'h000, 8'h01);
    wr(9'h16e, 8'h8b);
    wait_n(60);
    chk(o_core_sleep, 1);
    wr(9'h000, 8'h00);
    n = 0;
    while (o_core_sleep === 1'b1 && n < 8)
      step(n);
    chk(o_core_sleep, 0);
    wr(9'h000, 8'h01);
    wr(9'h16e, 8'h28);
    wait_n(2);
    chk(o_core_sleep, 0);
    wr(9'h16b, 8'h00);
    rd(9'h170);
    chk(rd_val, 8'h08);
  endtask

  // Main sequence
  initial
  begin
    i_rst = 1'b1;
    i_addr = 9'h000;
    i_wdata = 8'h00;
    i_write = 1'b0;
    i_read = 1'b0;
    i_foreground_done = 1'b0;
    i_cal_stopped = 1'b0;
    i_alarm = 1'b0;
    i_cal_phase_done = 1'b0;
    n_fail = 0;
    n_tests = 0;
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    t_reset();
    t_status();
    t_irq();
    t_trigger();
    t_lp();
    t_trig_wake();
    tally_and_finish();
  end
endmodule
